// >>> src/page_mode_dram_controller.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
// fast page-mode dram controller with cas-before-ras refresh
//
// Contract
// - reads start with data bus released, write high
// - row address out, then row strobe low
// - column address, column strobe low, then release
// - capture on return strobe rise; single ends row
// - page read keeps row, new column, restrobe
// - page read raises row strobe after column strobe, on return strobe rise
// - write starts with write strobe low first
// - column address and write data together
// - column strobe low commits write word
// - single write ends; page write restrobes
// - last page write word ends both strobes
// - refresh column strobe leads row strobe
// - refresh asserts row, then releases both
// - bit 15 disables all refresh
// - bits 12:0 plus one give refresh interval clocks
// - read data sampled on core clock at looped-back strobe rise
// - later page writes take two clocks; page reads wait for return strobe rise
// - strobes and address change on core clock
// - two splits: 10/8 and 9/9 row/column
// - address bit 19 picks bank row strobe
module page_mode_dram_controller #(
   parameter int DATA_W = 16,
   parameter int ADDR_W = 20,
   parameter int MA_W   = 10
)(
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // register port
   input  wire logic [7:0]        reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [15:0]            reg_rdata,
   // access request port
   input  wire logic              acc_valid,
   input  wire logic              acc_write,
   input  wire logic [ADDR_W-1:0] acc_addr,
   input  wire logic [DATA_W-1:0] acc_wdata,
   input  wire logic              acc_last,
   input  wire logic              split_9_9,
   output logic                   acc_ready,
   output logic                   busy,
   output logic [DATA_W-1:0]      rd_data,
   output logic                   rd_valid,
   // dram pins
   output logic [MA_W-1:0]        mem_addr_bus,
   output logic [DATA_W-1:0]      mem_data_out,
   output logic                   mem_data_oe_n,
   input  wire logic [DATA_W-1:0] mem_data_in,
   output logic                   mem_write_strobe_n,
   output logic                   row_strobe0_n,
   output logic                   row_strobe1_n,
   output logic                   col_strobe_lo_n,
   output logic                   col_strobe_hi_n,
   input  wire logic              col_strobe_return
);
   initial
   begin
      if (DATA_W != 16 || ADDR_W != 20 || MA_W != 10)
      begin
         $error("page_mode_dram_controller: only 16/20/10 widths supported");
      end
   end

   typedef struct packed
   {
      dram_ctrl_pkg::dram_state_t state;
      logic [15:0]                ref_ctrl;
      logic                       is_write;
      logic                       bank;
      logic [ADDR_W-1:0]          addr;
      logic [DATA_W-1:0]          wdata;
      logic                       last;
      logic                       split99;
      logic [MA_W-1:0]            ma;
      logic [DATA_W-1:0]          dout;
      logic                       oe_n;
      logic                       we_n;
      logic                       ras_n;
      logic                       cas_n;
      logic                       ret_q;
      logic                       ret_seen;
      logic [DATA_W-1:0]          rdata;
      logic                       rvalid;
      logic [15:0]                bus_rdata;
   } ctrl_state_t;

   ctrl_state_t st_reg;
   ctrl_state_t st_next;
   logic        ref_req;
   logic        ref_grant;
   logic        ret_rise;

   refresh_timer #(
      .INTERVAL_W (dram_ctrl_pkg::REF_INTERVAL_W)
   ) u_refresh_timer (
      .clk_sys         (clk_sys),
      .rst_n           (rst_n),
      .disable_refresh (st_reg.ref_ctrl[dram_ctrl_pkg::REF_DISABLE_BIT]),
      .interval        (st_reg.ref_ctrl[dram_ctrl_pkg::REF_INTERVAL_MSB:0]),
      .grant           (ref_grant),
      .request         (ref_req)
   );

   // the return strobe is sampled on the core clock; its rise marks data valid
   assign ret_rise = col_strobe_return && !st_reg.ret_q;

   function automatic logic [MA_W-1:0] row_of(input logic [ADDR_W-1:0] a,
                                              input logic split);
      logic [MA_W-1:0] r;
      r = {1'b0, a[17:9]};
      if (!split)
      begin
         r = {a[8], a[17:9]};
      end
      return r;
   endfunction

   function automatic logic [MA_W-1:0] col_of(input logic [ADDR_W-1:0] a,
                                              input logic split);
      logic [MA_W-1:0] c;
      c = {2'b00, a[7:0]};
      if (split)
      begin
         c = {1'b0, a[8:0]};
      end
      return c;
   endfunction

   assign ref_grant = (st_reg.state == dram_ctrl_pkg::ST_IDLE) && ref_req;
   assign acc_ready = ((st_reg.state == dram_ctrl_pkg::ST_IDLE) && !ref_req)
                      || ((st_reg.state == dram_ctrl_pkg::ST_COL_HOLD)
                          && !st_reg.last && (st_reg.is_write || ret_rise));

   always_comb
   begin
      st_next           = st_reg;
      st_next.ret_q     = col_strobe_return;
      st_next.rvalid    = 1'b0;
      st_next.bus_rdata = dram_ctrl_pkg::REG_MAP_RESERVED_RD;

      if (reg_wr && reg_addr == dram_ctrl_pkg::REFRESH_CTRL_OFFSET)
      begin
         // reserved bits 14:13 are stored as written; software keeps them zero
         st_next.ref_ctrl = reg_wdata;
      end
      if (reg_rd)
      begin
         unique case (reg_addr)
            dram_ctrl_pkg::STATUS_OFFSET:
               st_next.bus_rdata = {11'h000, ref_req, st_reg.state};
            dram_ctrl_pkg::RDATA_OFFSET:
               st_next.bus_rdata = st_reg.rdata;
            default:
               st_next.bus_rdata = dram_ctrl_pkg::REG_MAP_RESERVED_RD;
         endcase
      end

      unique case (st_reg.state)
         dram_ctrl_pkg::ST_IDLE:
         begin
            st_next.oe_n  = 1'b1;
            st_next.we_n  = 1'b1;
            st_next.ras_n = 1'b1;
            st_next.cas_n = 1'b1;
            if (ref_req)
            begin
               st_next.cas_n = 1'b0;
               st_next.state = dram_ctrl_pkg::ST_REF_CAS;
            end
            else if (acc_valid)
            begin
               st_next.is_write = acc_write;
               st_next.bank     = acc_addr[19];
               st_next.addr     = acc_addr;
               st_next.wdata    = acc_wdata;
               st_next.last     = acc_last;
               st_next.split99  = split_9_9;
               st_next.we_n     = !acc_write;
               st_next.oe_n     = 1'b1;
               st_next.state    = dram_ctrl_pkg::ST_SETUP;
            end
         end
         dram_ctrl_pkg::ST_SETUP:
         begin
            st_next.ma    = row_of(st_reg.addr, st_reg.split99);
            st_next.state = dram_ctrl_pkg::ST_ROW;
         end
         dram_ctrl_pkg::ST_ROW:
         begin
            st_next.ras_n = 1'b0;
            st_next.state = dram_ctrl_pkg::ST_COL;
         end
         dram_ctrl_pkg::ST_COL:
         begin
            st_next.ma = col_of(st_reg.addr, st_reg.split99);
            if (st_reg.is_write)
            begin
               st_next.dout = st_reg.wdata;
               st_next.oe_n = 1'b0;
            end
            st_next.state = dram_ctrl_pkg::ST_PRE;
         end
         dram_ctrl_pkg::ST_PRE:
         begin
            st_next.cas_n    = 1'b0;
            st_next.ret_seen = 1'b0;
            st_next.state    = dram_ctrl_pkg::ST_COL_HOLD;
         end
         dram_ctrl_pkg::ST_COL_HOLD:
         begin
            st_next.cas_n = 1'b1;
            if (st_reg.is_write || ret_rise)
            begin
               if (!st_reg.is_write)
               begin
                  st_next.rdata  = mem_data_in;
                  st_next.rvalid = 1'b1;
               end
               if (st_reg.last)
               begin
                  st_next.ras_n = 1'b1;
                  st_next.we_n  = 1'b1;
                  st_next.oe_n  = 1'b1;
                  st_next.state = dram_ctrl_pkg::ST_IDLE;
               end
               else if (acc_valid)
               begin
                  // next page word: address plus strobe in two clocks
                  st_next.addr  = acc_addr;
                  st_next.wdata = acc_wdata;
                  st_next.last  = acc_last;
                  st_next.ma    = col_of(acc_addr, st_reg.split99);
                  if (st_reg.is_write)
                  begin
                     st_next.dout = acc_wdata;
                  end
                  st_next.state = dram_ctrl_pkg::ST_PRE;
               end
            end
         end
         dram_ctrl_pkg::ST_REF_CAS:
         begin
            st_next.ras_n = 1'b0;
            st_next.state = dram_ctrl_pkg::ST_REF_RAS;
         end
         dram_ctrl_pkg::ST_REF_RAS:
         begin
            st_next.ras_n = 1'b1;
            st_next.cas_n = 1'b1;
            st_next.state = dram_ctrl_pkg::ST_REF_END;
         end
         dram_ctrl_pkg::ST_REF_END:
         begin
            st_next.state = dram_ctrl_pkg::ST_IDLE;
         end
         default:
         begin
            st_next.state = dram_ctrl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg          <= '0;
         st_reg.state    <= dram_ctrl_pkg::ST_IDLE;
         st_reg.ref_ctrl <= dram_ctrl_pkg::REF_CTRL_RESET;
         st_reg.oe_n     <= 1'b1;
         st_reg.we_n     <= 1'b1;
         st_reg.ras_n    <= 1'b1;
         st_reg.cas_n    <= 1'b1;
         st_reg.ret_q    <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // refresh strobes both banks; accesses pick one by the bank bit
   assign row_strobe0_n      = st_reg.ras_n | (st_reg.bank & !ref_active());
   assign row_strobe1_n      = st_reg.ras_n | (!st_reg.bank & !ref_active());
   assign col_strobe_lo_n    = st_reg.cas_n;
   assign col_strobe_hi_n    = st_reg.cas_n;
   assign mem_addr_bus       = st_reg.ma;
   assign mem_data_out       = st_reg.dout;
   assign mem_data_oe_n      = st_reg.oe_n;
   assign mem_write_strobe_n = st_reg.we_n;
   assign rd_data            = st_reg.rdata;
   assign rd_valid           = st_reg.rvalid;
   assign reg_rdata          = st_reg.bus_rdata;
   assign busy               = st_reg.state != dram_ctrl_pkg::ST_IDLE;

   function automatic logic ref_active();
      return st_reg.state == dram_ctrl_pkg::ST_REF_CAS
          || st_reg.state == dram_ctrl_pkg::ST_REF_RAS;
   endfunction
endmodule

// >>> src/dram_ctrl_pkg.sv
// constants, states and register layout for the page-mode dram controller
package dram_ctrl_pkg;
   localparam logic [7:0]  REFRESH_CTRL_OFFSET = 8'h33;
   localparam logic [7:0]  STATUS_OFFSET       = 8'h34;
   localparam logic [7:0]  RDATA_OFFSET        = 8'h35;
   localparam int          REF_DISABLE_BIT     = 15;
   localparam int          REF_INTERVAL_MSB    = 12;
   localparam int          REF_INTERVAL_W      = 13;
   localparam logic [15:0] REF_CTRL_RESET      = 16'h0000;
   localparam logic [12:0] REF_INTERVAL_DEFAULT = 13'h0138;
   localparam logic [15:0] REG_MAP_RESERVED_RD = 16'h0000;

   typedef enum logic [3:0]
   {
      ST_IDLE     = 4'b0000,
      ST_SETUP    = 4'b0001,
      ST_ROW      = 4'b0010,
      ST_COL      = 4'b0011,
      ST_COL_HOLD = 4'b0100,
      ST_PRE      = 4'b0101,
      ST_REF_CAS  = 4'b0110,
      ST_REF_RAS  = 4'b0111,
      ST_REF_END  = 4'b1000
   } dram_state_t;
endpackage

// >>> src/refresh_timer.sv
`timescale 1ns/1ps
// refresh interval down-counter with sticky request
module refresh_timer #(
   parameter int INTERVAL_W = 13
)(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  disable_refresh,
   input  wire logic [INTERVAL_W-1:0] interval,
   input  wire logic                  grant,
   output logic                       request
);
   typedef struct packed
   {
      logic [INTERVAL_W-1:0] count;
      logic                  req;
   } timer_state_t;

   timer_state_t st_reg;
   timer_state_t st_next;

   initial
   begin
      if (INTERVAL_W < 2 || INTERVAL_W > 16)
      begin
         $error("refresh_timer: unsupported INTERVAL_W");
      end
   end

   always_comb
   begin
      st_next = st_reg;
      if (disable_refresh)
      begin
         st_next.count = interval;
         st_next.req   = 1'b0;
      end
      else
      begin
         if (grant)
         begin
            st_next.req = 1'b0;
         end
         if (st_reg.count == '0)
         begin
            st_next.count = interval;
            st_next.req   = 1'b1;
         end
         else
         begin
            st_next.count = st_reg.count - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign request = st_reg.req;
endmodule

// >>> tb/page_mode_dram_controller_checker.sv
`timescale 1ns/1ps
// pin protocol assertions for the page-mode dram controller
module page_mode_dram_controller_checker #(
   parameter int DATA_W = 16,
   parameter int MA_W   = 10
)(
   input wire logic              clk_sys,
   input wire logic              rst_n,
   input wire logic              acc_valid,
   input wire logic              acc_write,
   input wire logic              acc_ready,
   input wire logic              busy,
   input wire logic              rd_valid,
   input wire logic [MA_W-1:0]   mem_addr_bus,
   input wire logic [DATA_W-1:0] mem_data_out,
   input wire logic              mem_data_oe_n,
   input wire logic              mem_write_strobe_n,
   input wire logic              row_strobe0_n,
   input wire logic              row_strobe1_n,
   input wire logic              col_strobe_lo_n,
   input wire logic              col_strobe_hi_n,
   input wire logic              col_strobe_return
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   logic take, one, both, ret_q, rise;
   assign take = acc_valid && acc_ready && !busy;
   assign one  = row_strobe0_n ^ row_strobe1_n;
   assign both = !row_strobe0_n && !row_strobe1_n;
   assign rise = col_strobe_return && !ret_q;
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
         ret_q <= 1'b1;
      else
         ret_q <= col_strobe_return;
   rd_release_a: assert property (take && !acc_write |=> (mem_data_oe_n && mem_write_strobe_n) [*4])
      else $error("read cycle drives data or write strobe");
   wr_first_a: assert property (take && acc_write |=> !mem_write_strobe_n && row_strobe0_n && row_strobe1_n)
      else $error("write strobe not first");
   row_addr_a: assert property (one && $past(row_strobe0_n && row_strobe1_n) |-> $stable(mem_addr_bus))
      else $error("row address moved at row strobe");
   cbr_a: assert property (both && $past(!both) |-> $past(!col_strobe_lo_n && row_strobe0_n && row_strobe1_n))
      else $error("refresh row strobe without leading column strobe");
   ref_end_a: assert property (both |-> ##[1:3] (row_strobe0_n && row_strobe1_n && col_strobe_lo_n))
      else $error("refresh not released");
   wr_commit_a: assert property ($fell(col_strobe_lo_n) && !mem_write_strobe_n && one
      |-> $stable(mem_addr_bus) && $stable(mem_data_out) && !mem_data_oe_n)
      else $error("write word not set up at column strobe");
   wr_page_a: assert property ($rose(col_strobe_lo_n) && one && !mem_write_strobe_n |-> ##[1:2] !col_strobe_lo_n)
      else $error("page write word too slow");
   wr_end_a: assert property (($rose(row_strobe0_n) || $rose(row_strobe1_n)) && $past(!mem_write_strobe_n) |-> $rose(col_strobe_lo_n))
      else $error("write end strobes not together");
   rd_end_a: assert property (($rose(row_strobe0_n) || $rose(row_strobe1_n)) && $past(one) |-> col_strobe_lo_n && col_strobe_hi_n)
      else $error("row strobe released with column strobe low");
   rd_latch_a: assert property (rd_valid |-> $past(rise) || $past(rise, 2))
      else $error("read word not tied to return strobe");
   ref_idle_a: assert property ($fell(col_strobe_lo_n) && row_strobe0_n && row_strobe1_n |-> $past(!busy))
      else $error("refresh started inside a burst");
endmodule

// >>> tb/dram_model.sv
`timescale 1ns/1ps
// behavioural fast page-mode dram pair with looped-back column strobe
module dram_model (
   input  wire logic        clk_sys,
   input  wire logic        split_9_9,
   input  wire logic [9:0]  mem_addr_bus,
   input  wire logic [15:0] mem_data_out,
   input  wire logic        mem_data_oe_n,
   input  wire logic        mem_write_strobe_n,
   input  wire logic        row_strobe0_n,
   input  wire logic        row_strobe1_n,
   input  wire logic        col_strobe_lo_n,
   input  wire logic        col_strobe_hi_n,
   output logic [15:0]      mem_data_in,
   output logic             col_strobe_return = 1'b1
);
   logic [15:0] mem [int];
   logic [15:0] cyc = 16'h0000;
   logic [15:0] word = 16'h0000;
   logic        cas_n;
   int          row = 0, key = 0, n_ref = 0;
   bit          hit = 0;
   assign cas_n = col_strobe_lo_n & col_strobe_hi_n;
   // released data lines show a changing pattern, never the old word
   assign mem_data_in = (hit && mem_write_strobe_n) ? word : cyc ^ 16'hA5A5;
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 16'h0001;
      col_strobe_return <= cas_n;
      // cleared after the edge, so the word still stands where the controller latches it
      if (cas_n && col_strobe_return)
         hit <= 0;
   end
   always @(negedge row_strobe0_n or negedge row_strobe1_n)
      if (cas_n)
         row = {row_strobe0_n, split_9_9 ? {1'b0, mem_addr_bus[8:0]} : mem_addr_bus};
   // refresh leaves row alone and is only counted in n_ref, the bus is ignored
   // both row strobes fall in one time step; settle before looking at the other
   always @(negedge row_strobe0_n)
      #1 if (!cas_n && !row_strobe1_n)
         n_ref++;
   always @(negedge cas_n)
      if (!(row_strobe0_n && row_strobe1_n))
      begin
         key = row * 1024 + (split_9_9 ? mem_addr_bus[8:0] : mem_addr_bus[7:0]);
         if (!mem_write_strobe_n)
            mem[key] = mem_data_oe_n ? ~mem_data_out : mem_data_out;
         else if (mem.exists(key))
            word = mem[key];
         else
            word = cyc ^ 16'h5A5A;
         hit = 1;
      end
endmodule

// >>> tb/page_mode_dram_controller_tb.sv
`timescale 1ns/1ps
// self-checking bench for the page-mode dram controller
module page_mode_dram_controller_tb;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
   $display("mismatch %0t got %h want %h", $time, a, b); end end
   logic        clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, acc_valid = 0, acc_write = 0;
   logic        acc_last = 0, split_9_9 = 0, acc_ready, busy, rd_valid, mem_data_oe_n;
   logic        mem_write_strobe_n, row_strobe0_n, row_strobe1_n, col_strobe_lo_n;
   logic        col_strobe_hi_n, col_strobe_return;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, acc_wdata = 16'h0000, reg_rdata, rd_data;
   logic [15:0] mem_data_out, mem_data_in;
   logic [19:0] acc_addr = 20'h00000;
   logic [9:0]  mem_addr_bus;
   int          n_errors = 0, cmp_count = 0, seed = 91332, refs;
   logic [15:0] model [int];
   logic [15:0] rd_q [$];
   logic [15:0] exp_w;
   logic [15:0] ivals [2] = '{16'h0020, 16'h1FFF};
   page_mode_dram_controller dut_u (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .acc_valid, .acc_write, .acc_addr, .acc_wdata, .acc_last, .split_9_9,
      .acc_ready, .busy, .rd_data, .rd_valid, .mem_addr_bus, .mem_data_out, .mem_data_oe_n,
      .mem_data_in, .mem_write_strobe_n, .row_strobe0_n, .row_strobe1_n, .col_strobe_lo_n,
      .col_strobe_hi_n, .col_strobe_return);
   dram_model mdl_u (.clk_sys, .split_9_9, .mem_addr_bus, .mem_data_out, .mem_data_oe_n,
      .mem_write_strobe_n, .row_strobe0_n, .row_strobe1_n, .col_strobe_lo_n,
      .col_strobe_hi_n, .mem_data_in, .col_strobe_return);
   initial
      forever #25 clk_sys = ~clk_sys;
   function automatic int dkey(logic [19:0] a, bit s);
      return (a[19] * 1024 + (s ? a[17:9] : {a[8], a[17:9]})) * 1024 + (s ? a[8:0] : a[7:0]);
   endfunction
   task automatic tally_and_finish;
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic reg_write(logic [7:0] a, logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_check(logic [7:0] a, logic [15:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 `CHK(reg_rdata, e)
   endtask
   // holds each word until the edge where acc_ready is seen high
   task automatic burst(bit wr, logic [19:0] a, int n);
      int          k;
      logic [15:0] d;
      for (int i = 0; i < n; i++)
      begin
         d = $random(seed);
         acc_valid <= 1'b1;
         acc_write <= wr;
         acc_addr <= a + i;
         acc_wdata <= d;
         acc_last <= (i == n - 1);
         k = 0;
         do @(negedge clk_sys); while (acc_ready !== 1'b1 && ++k < 400);
         if (k >= 400)
         begin
            n_errors++;
            tally_and_finish();
         end
         @(posedge clk_sys);
         if (wr)
            model[a + i] = d;
         else
            rd_q.push_back(model[a + i]);
      end
      acc_valid <= 1'b0;
   endtask
   // sampled mid-cycle, away from the edge that launches rd_valid
   always @(negedge clk_sys)
      if (rd_valid === 1'b1)
      begin
         exp_w = rd_q.size() ? rd_q.pop_front() : 16'hXXXX;
         `CHK(rd_data, exp_w)
      end
   initial
   begin
      logic [19:0] a;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      reg_check(8'h33, 16'h0000);
      reg_check(8'h7F, 16'h0000);
      foreach (ivals[i])
      begin
         reg_write(8'h33, ivals[i]);
         refs = mdl_u.n_ref;
         repeat (4 * (ivals[i] + 1)) @(posedge clk_sys);
         `CHK(mdl_u.n_ref - refs inside {[3:5]}, 1'b1)
      end
      reg_write(8'h33, 16'h8010);
      refs = mdl_u.n_ref;
      repeat (600) @(posedge clk_sys);
      `CHK(mdl_u.n_ref - refs, 0)
      // short interval so refreshes fall between bursts
      reg_write(8'h33, 16'h0030);
      for (int j = 0; j < 12; j++)
      begin
         split_9_9 <= j[1];
         a = $random(seed);
         a[18] = 1'b0;
         a[2:0] = 3'h0;
         burst(1'b1, a, 1 + j % 4);
         burst(1'b0, a, 1 + j % 4);
         repeat (30) @(posedge clk_sys);
         for (int i = 0; i <= j % 4; i++)
            `CHK(mdl_u.mem[dkey(a + i, j[1])], model[a + i])
      end
      `CHK(rd_q.size(), 0)
      tally_and_finish();
   end
endmodule
bind page_mode_dram_controller page_mode_dram_controller_checker #(.DATA_W(DATA_W), .MA_W(MA_W))
   chk_u (.clk_sys, .rst_n, .acc_valid, .acc_write, .acc_ready, .busy, .rd_valid,
   .mem_addr_bus, .mem_data_out, .mem_data_oe_n, .mem_write_strobe_n, .row_strobe0_n,
   .row_strobe1_n, .col_strobe_lo_n, .col_strobe_hi_n, .col_strobe_return);
